// file: bench/lcea_chk.sv
// assertions on the line-cycle accumulator top-level ports
// assumes a bind onto lcea_top
`timescale 1ns/1ps
`default_nettype none
`include "lcea_consts.vh"
// ==========================================================
// checker
module lcea_chk #(
  parameter NPH   = 3,
  parameter NRG_W = 32,
  parameter TGT_W = 16
) (
  // clock and reset
  input wire logic                    sys_clk,
  input wire logic                    resetn,
  // writes and crossings
  input wire logic                    mode_wr,
  input wire logic                    target_wr,
  input wire logic [TGT_W-1:0]        target_wdata,
  input wire logic                    status_wr,
  input wire logic [`LCEA_STAT_W-1:0] status_wdata,
  input wire logic [NPH-1:0]          zx_pulse,
  // registers and interrupt
  input wire logic [`LCEA_MODE_W-1:0] line_cycle_mode_reg,
  input wire logic [TGT_W-1:0]        half_cycle_count_target,
  input wire logic [`LCEA_STAT_W-1:0] first_irq_mask_reg,
  input wire logic [`LCEA_STAT_W-1:0] first_status_reg,
  input wire logic [TGT_W-1:0]        zx_count,
  input wire logic                    first_irq_out_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire logic             en   = line_cycle_mode_reg[0];
  wire logic             flg  = first_status_reg[5];
  wire logic             one  = $onehot(zx_pulse & line_cycle_mode_reg[5:3]);
  wire logic [TGT_W-1:0] nxt  = zx_count + 16'h0001;
  wire logic             hold = !target_wr && !mode_wr;
  a_irq_low: assert property ($rose(flg) && first_irq_mask_reg[5] |-> !first_irq_out_n)
    else $error("interrupt not low on done");
  a_clear_one: assert property (status_wr && status_wdata[5] && !en |=> !flg && first_irq_out_n)
    else $error("done flag not cleared");
  a_zero_keeps: assert property (status_wr && !status_wdata[5] && flg |=> flg)
    else $error("done flag lost on zero write");
  a_tgt_resets: assert property (target_wr && en |=> zx_count == 16'h0000)
    else $error("count not reset by target write");
  a_tgt_stores: assert property (target_wr |=> half_cycle_count_target == $past(target_wdata))
    else $error("target not stored");
  a_flag_cause: assert property ($rose(flg) |-> $past(en) && $past(half_cycle_count_target) != 16'h0000)
    else $error("done without enable or target");
  a_count_runs: assert property (hold && one && nxt < half_cycle_count_target |=> zx_count == $past(nxt))
    else $error("count did not advance");
  a_hit_restart: assert property (hold && one && en && nxt == half_cycle_count_target |=> zx_count == 16'h0000 ##0 flg)
    else $error("no restart and done at target");
endmodule
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench for the line-cycle accumulator
// assumes lcea_top with default widths on one 50 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "lcea_consts.vh"
// ==========================================================
// bench
module testbench;
  typedef struct packed {
    logic [2:0]  sel;
    logic [2:0]  zx;
    logic [1:0]  n;
    logic [15:0] tgt;
    logic        done;
    logic [15:0] cnt;
  } lcea_row_t;
  logic        sys_clk, resetn, mode_wr, target_wr, mask_wr, status_wr;
  logic [6:0]  mode_wdata;
  logic [15:0] target_wdata;
  logic [31:0] mask_wdata, status_wdata, acc_t [3], acc_f [3];
  logic [2:0]  zx_pulse, tot_pulse, tot_neg, fund_pulse, fund_neg;
  logic [5:0]  whr_access, whr_read_done;
  wire  [6:0]  mode_q;
  wire  [15:0] tgt_q, cnt_q;
  wire  [31:0] mask_q, stat_q;
  wire  [95:0] tot_q, fund_q;
  wire         irq_n;
  int          err_count, cmp_count;
  lcea_row_t   rows [5] = '{
    '{3'h3, 3'h7, 2'h1, 16'h0005, 1'b0, 16'h0002},
    '{3'h1, 3'h1, 2'h3, 16'h0003, 1'b1, 16'h0000},
    '{3'h2, 3'h2, 2'h2, 16'h0002, 1'b1, 16'h0000},
    '{3'h4, 3'h7, 2'h2, 16'h0002, 1'b1, 16'h0000},
    '{3'h7, 3'h7, 2'h1, 16'h0003, 1'b1, 16'h0000}};
  lcea_top i_dut (.sys_clk(sys_clk), .resetn(resetn), .mode_wr(mode_wr),
    .mode_wdata(mode_wdata), .target_wr(target_wr), .target_wdata(target_wdata),
    .mask_wr(mask_wr), .mask_wdata(mask_wdata), .status_wr(status_wr),
    .status_wdata(status_wdata), .zx_pulse(zx_pulse), .tot_pulse(tot_pulse),
    .tot_neg(tot_neg), .fund_pulse(fund_pulse), .fund_neg(fund_neg),
    .whr_access(whr_access), .whr_read_done(whr_read_done),
    .line_cycle_mode_reg(mode_q), .half_cycle_count_target(tgt_q),
    .first_irq_mask_reg(mask_q), .first_status_reg(stat_q), .zx_count(cnt_q),
    .total_active_energy_reg(tot_q), .fund_active_energy_reg(fund_q),
    .first_irq_out_n(irq_n));
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wreg(input int k, input logic [31:0] d);
    {mode_wr, target_wr, mask_wr, status_wr} = 4'h8 >> k;
    mode_wdata = d[6:0];
    target_wdata = d[15:0];
    mask_wdata = d;
    status_wdata = d;
    step();
    {mode_wr, target_wr, mask_wr, status_wr} = 4'h0;
    step();
  endtask
  // energy pulses: total A+ B- C+, fundamental A+ C-
  task automatic cyc(input logic [2:0] zx, input logic e);
    zx_pulse = zx;
    tot_pulse = {3{e}};
    fund_pulse = {e, 1'b0, e};
    step();
    {zx_pulse, tot_pulse, fund_pulse} = 9'h000;
    step();
    if (e) begin
      acc_t[0]++;
      acc_t[1]--;
      acc_t[2]++;
      acc_f[0]++;
      acc_f[2]--;
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    #200000;
    err_count++;
    summarize();
  end
  initial begin
    {mode_wr, target_wr, mask_wr, status_wr, mode_wdata, target_wdata} = '0;
    {mask_wdata, status_wdata, zx_pulse, tot_pulse, fund_pulse} = '0;
    {whr_access, whr_read_done, tot_neg, fund_neg} = {12'h000, 3'h2, 3'h4};
    acc_t = '{3{32'h0000_0000}};
    acc_f = '{3{32'h0000_0000}};
    resetn = 0;
    repeat (4) @(posedge sys_clk);
    #1 resetn = 1;
    step();
    chk(32'(mode_q), 32'h0000_0038);
    chk(32'(tgt_q), 32'h0000_0000);
    chk(32'(irq_n), 32'h0000_0001);
    chk(stat_q | tot_q[31:0], 32'h0000_0000);
    chk(mask_q, 32'h0000_0000);
    $display("reset done");
    wreg(2, 32'h0000_0020);
    chk(mask_q, 32'h0000_0020);
    foreach (rows[r]) begin
      wreg(3, 32'h0000_0020);
      wreg(0, {26'h0, rows[r].sel, 3'h1});
      wreg(1, 32'(rows[r].tgt));
      for (int i = 0; i < rows[r].n; i++) begin
        cyc(3'h0, 1'b1);
        cyc(rows[r].zx, 1'b0);
      end
      chk(32'(stat_q[5]), 32'(rows[r].done));
      chk(32'(irq_n), 32'(!rows[r].done));
      chk(32'(cnt_q), 32'(rows[r].cnt));
      for (int p = 0; p < 3 && rows[r].done; p++) begin
        chk(tot_q[32*p +: 32], acc_t[p]);
        chk(fund_q[32*p +: 32], acc_f[p]);
        acc_t[p] = 32'h0000_0000;
        acc_f[p] = 32'h0000_0000;
      end
      $display("row %0d done", r);
    end
    wreg(0, 32'h0000_0008);
    wreg(3, 32'h0000_0000);
    chk(32'(stat_q[5]), 32'h0000_0001);
    chk(32'(irq_n), 32'h0000_0000);
    wreg(3, 32'h0000_0020);
    chk({stat_q[5], irq_n}, 32'h0000_0001);
    $display("status clear done");
    wreg(1, 32'h0000_0002);
    cyc(3'h1, 1'b0);
    cyc(3'h1, 1'b0);
    chk({cnt_q, stat_q[5]}, 32'h0000_0000);
    cyc(3'h1, 1'b0);
    wreg(0, 32'h0000_0009);
    chk(32'(cnt_q), 32'h0000_0001);
    wreg(1, 32'h0000_0002);
    chk(32'(cnt_q), 32'h0000_0000);
    $display("counter runs done");
    wreg(1, 32'h0000_0000);
    cyc(3'h1, 1'b1);
    cyc(3'h1, 1'b0);
    chk({cnt_q, stat_q[5]}, 32'h0000_0000);
    $display("zero target done");
    // normal mode: clear on read, then access adds the accumulator
    wreg(0, 32'h0000_0040);
    whr_read_done = 6'h3F;
    step();
    whr_read_done = 6'h00;
    for (int p = 0; p < 3; p++) begin
      chk(tot_q[32*p +: 32], 32'h0000_0000);
      chk(fund_q[32*p +: 32], 32'h0000_0000);
    end
    whr_access = 6'h3F;
    step();
    whr_access = 6'h00;
    for (int p = 0; p < 3; p++) begin
      chk(tot_q[32*p +: 32], acc_t[p]);
      chk(fund_q[32*p +: 32], acc_f[p]);
    end
    $display("normal mode done");
    summarize();
  end
endmodule
bind lcea_top lcea_chk #(.NPH(NPH), .NRG_W(NRG_W), .TGT_W(TGT_W)) i_chk (
  .sys_clk(sys_clk), .resetn(resetn), .mode_wr(mode_wr), .target_wr(target_wr),
  .target_wdata(target_wdata), .status_wr(status_wr), .status_wdata(status_wdata),
  .zx_pulse(zx_pulse), .line_cycle_mode_reg(line_cycle_mode_reg),
  .half_cycle_count_target(half_cycle_count_target),
  .first_irq_mask_reg(first_irq_mask_reg), .first_status_reg(first_status_reg),
  .zx_count(zx_count), .first_irq_out_n(first_irq_out_n));
`default_nettype wire

// file: hw/lcea_energy_acc.v
// one internal energy accumulator and its watt-hour register
// assumes energy pulses arrive from the power path on the same clock
`include "lcea_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module lcea_energy_acc #(
  parameter NRG_W = `LCEA_NRG_W
) (
  // clock and reset
  input  wire             sys_clk,
  input  wire             resetn,
  // energy pulses
  input  wire             nrg_pulse,
  input  wire             nrg_neg,
  // control
  input  wire             lc_mode,
  input  wire             lc_xfer,
  input  wire             clr_on_read,
  input  wire             whr_access,
  input  wire             whr_read_done,
  // result
  output reg  [NRG_W-1:0] whr_r
);

  // ==========================================================
  // signed step, wraps in two's complement
  reg  [NRG_W-1:0] acc_r;
  wire [NRG_W-1:0] step;

  assign step = !nrg_pulse ? {NRG_W{1'b0}} :
                nrg_neg    ? {NRG_W{1'b1}} :
                             {{(NRG_W-1){1'b0}}, 1'b1};

  // ==========================================================
  // accumulator and watt-hour register
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acc_r <= `LCEA_NRG_RST;
      whr_r <= `LCEA_NRG_RST;
    end else if (lc_mode && lc_xfer) begin
      whr_r <= acc_r;
      acc_r <= step;
    end else if (!lc_mode && whr_access) begin
      whr_r <= whr_r + acc_r;
      acc_r <= step;
    end else begin
      acc_r <= acc_r + step;
      if (!lc_mode && clr_on_read && whr_read_done) begin
        whr_r <= `LCEA_NRG_RST;
      end
    end
  end

endmodule
`default_nettype wire

// file: hw/lcea_top.v
// line-cycle active energy accumulator, top level
// assumes register writes arrive as strobes from the host serial port
// logic, and crossing and energy pulses from the same-clock signal path
//
// Summary of operation
// - energy transfer is timed by voltage zero crossings in line-cycle mode
// - mode register bit 0 set enables line-cycle accumulation
// - on reaching the count, 32-bit accumulators copy into watt-hour registers
// - bits 5 to 3 pick phases C, B, A crossings, any combination
// - target is a 16-bit unsigned register, up to 65535 crossings
// - crossing counter runs whether or not enabled (held at zero while target is zero), so first result after enable may be partial
// - target write while enabled resets the crossing counter
// - end of each period sets done flag, status bit 5
// - with mask bit set, done flag drives the interrupt output low
// - writing one to status bit 5 clears flag; zero leaves it
// - same energy path and LSB weight as normal accumulation
// - watt-hour registers are signed 32-bit and wrap both ways
`include "lcea_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module lcea_top #(
  parameter NPH   = `LCEA_PHASES,
  parameter NRG_W = `LCEA_NRG_W,
  parameter TGT_W = `LCEA_TGT_W
) (
  // clock and reset
  input  wire                 sys_clk,
  input  wire                 resetn,
  // mode register write
  input  wire                 mode_wr,
  input  wire [`LCEA_MODE_W-1:0] mode_wdata,
  // target register write
  input  wire                 target_wr,
  input  wire [TGT_W-1:0]     target_wdata,
  // mask register write
  input  wire                 mask_wr,
  input  wire [`LCEA_STAT_W-1:0] mask_wdata,
  // status register write, ones clear
  input  wire                 status_wr,
  input  wire [`LCEA_STAT_W-1:0] status_wdata,
  // zero crossings from the voltage channels
  input  wire [NPH-1:0]       zx_pulse,
  // energy pulses from the power path
  input  wire [NPH-1:0]       tot_pulse,
  input  wire [NPH-1:0]       tot_neg,
  input  wire [NPH-1:0]       fund_pulse,
  input  wire [NPH-1:0]       fund_neg,
  // watt-hour access strobes, total then fundamental
  input  wire [2*NPH-1:0]     whr_access,
  input  wire [2*NPH-1:0]     whr_read_done,
  // register read-back
  output reg  [`LCEA_MODE_W-1:0] line_cycle_mode_reg,
  output reg  [TGT_W-1:0]     half_cycle_count_target,
  output reg  [`LCEA_STAT_W-1:0] first_irq_mask_reg,
  output wire [`LCEA_STAT_W-1:0] first_status_reg,
  output wire [TGT_W-1:0]     zx_count,
  // energy results
  output wire [NPH*NRG_W-1:0] total_active_energy_reg,
  output wire [NPH*NRG_W-1:0] fund_active_energy_reg,
  // interrupt
  output reg                  first_irq_out_n
);

  // ==========================================================
  // mode fields
  wire           line_cycle_enable;
  wire [NPH-1:0] zero_cross_phase_select;
  wire           clear_on_read_enable;

  assign line_cycle_enable       = line_cycle_mode_reg[`LCEA_MODE_EN_BIT];
  assign zero_cross_phase_select =
    line_cycle_mode_reg[`LCEA_MODE_ZERO_CROSS_PHASE_SELECT_MSB:`LCEA_MODE_ZERO_CROSS_PHASE_SELECT_LSB];
  assign clear_on_read_enable    = line_cycle_mode_reg[`LCEA_MODE_CLRRD_BIT];

  // ==========================================================
  // configuration registers
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      line_cycle_mode_reg     <= `LCEA_MODE_RST;
      half_cycle_count_target <= `LCEA_TGT_RST;
      first_irq_mask_reg      <= `LCEA_MASK_RST;
    end else begin
      if (mode_wr) begin
        line_cycle_mode_reg <= mode_wdata;
      end
      if (target_wr) begin
        half_cycle_count_target <= target_wdata;
      end
      if (mask_wr) begin
        first_irq_mask_reg <= mask_wdata;
      end
    end
  end

  // ==========================================================
  // selected crossings, each counts once
  wire [NPH-1:0] zx_sel;
  wire [1:0]     zx_inc;
  wire           cnt_clr;
  wire           cnt_hit;
  wire           lc_xfer;

  assign zx_sel  = zx_pulse & zero_cross_phase_select;
  assign zx_inc  = {1'b0, zx_sel[0]} + {1'b0, zx_sel[1]} +
                   {1'b0, zx_sel[2]};
  assign cnt_clr = target_wr && line_cycle_enable;
  assign lc_xfer = cnt_hit && line_cycle_enable && !cnt_clr;

  lcea_zx_counter #(
    .CNT_W (TGT_W)
  ) u_zx_counter (
    .sys_clk    (sys_clk),
    .resetn     (resetn),
    .cnt_clr    (cnt_clr),
    .cnt_inc    (zx_inc),
    .cnt_target (half_cycle_count_target),
    .cnt_r      (zx_count),
    .cnt_hit    (cnt_hit)
  );

  // ==========================================================
  // accumulators, total then fundamental
  wire [2*NPH-1:0]       acc_pulse;
  wire [2*NPH-1:0]       acc_neg;
  wire [2*NPH*NRG_W-1:0] whr_all;

  assign acc_pulse = {fund_pulse, tot_pulse};
  assign acc_neg   = {fund_neg, tot_neg};

  genvar gi;
  generate
    for (gi = 0; gi < 2*NPH; gi = gi + 1) begin : g_acc
      lcea_energy_acc #(
        .NRG_W (NRG_W)
      ) u_acc (
        .sys_clk       (sys_clk),
        .resetn        (resetn),
        .nrg_pulse     (acc_pulse[gi]),
        .nrg_neg       (acc_neg[gi]),
        .lc_mode       (line_cycle_enable),
        .lc_xfer       (lc_xfer),
        .clr_on_read   (clear_on_read_enable),
        .whr_access    (whr_access[gi]),
        .whr_read_done (whr_read_done[gi]),
        .whr_r         (whr_all[gi*NRG_W +: NRG_W])
      );
    end
  endgenerate

  assign total_active_energy_reg = whr_all[NPH*NRG_W-1:0];
  assign fund_active_energy_reg  = whr_all[2*NPH*NRG_W-1:NPH*NRG_W];

  // ==========================================================
  // done flag and interrupt
  reg  line_cycle_done_flag;
  wire done_nxt;
  wire done_clr;

  assign done_clr = status_wr && status_wdata[`LCEA_STAT_DONE_BIT];
  assign done_nxt = lc_xfer || (line_cycle_done_flag && !done_clr);

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      line_cycle_done_flag <= 1'b0;
      first_irq_out_n      <= 1'b1;
    end else begin
      line_cycle_done_flag <= done_nxt;
      first_irq_out_n      <= !(done_nxt &&
        (mask_wr ? mask_wdata[`LCEA_STAT_DONE_BIT] :
                   first_irq_mask_reg[`LCEA_STAT_DONE_BIT]));
    end
  end

  assign first_status_reg = `LCEA_STAT_RST |
    ({{(`LCEA_STAT_W-1){1'b0}}, line_cycle_done_flag} << `LCEA_STAT_DONE_BIT);

endmodule
`default_nettype wire

// file: hw/lcea_zx_counter.v
// half-line-cycle counter for the line-cycle accumulator
// assumes crossing pulses come from logic on the same clock
`include "lcea_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module lcea_zx_counter #(
  parameter CNT_W = `LCEA_TGT_W
) (
  // clock and reset
  input  wire             sys_clk,
  input  wire             resetn,
  // control
  input  wire             cnt_clr,
  input  wire [1:0]       cnt_inc,
  input  wire [CNT_W-1:0] cnt_target,
  // status
  output reg  [CNT_W-1:0] cnt_r,
  output wire             cnt_hit
);

  // ==========================================================
  // next count
  wire [CNT_W:0] cnt_sum;
  wire           tgt_zero;

  assign cnt_sum  = {1'b0, cnt_r} + {{(CNT_W-1){1'b0}}, cnt_inc};
  assign tgt_zero = (cnt_target == {CNT_W{1'b0}});
  assign cnt_hit  = !tgt_zero && (cnt_inc != 2'b00) &&
                    (cnt_sum >= {1'b0, cnt_target});

  // ==========================================================
  // counter, runs whether or not enabled, held at zero while the target is zero
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= {CNT_W{1'b0}};
    end else if (cnt_clr) begin
      cnt_r <= {CNT_W{1'b0}};
    end else if (tgt_zero || cnt_hit) begin
      cnt_r <= {CNT_W{1'b0}};
    end else begin
      cnt_r <= cnt_sum[CNT_W-1:0];
    end
  end

endmodule
`default_nettype wire

// file: shared/lcea_consts.vh
// constants for the line-cycle active energy accumulator
// assumes a single device clock; included by its bare name
`ifndef LCEA_CONSTS_VH
`define LCEA_CONSTS_VH

// ==========================================================
// line-cycle mode register fields
`define LCEA_MODE_W            7
`define LCEA_MODE_EN_BIT       0
`define LCEA_MODE_ZERO_CROSS_PHASE_SELECT_LSB    3
`define LCEA_MODE_ZERO_CROSS_PHASE_SELECT_MSB    5
`define LCEA_MODE_CLRRD_BIT    6
`define LCEA_MODE_RST          7'h38

// ==========================================================
// half-cycle target register
`define LCEA_TGT_W             16
`define LCEA_TGT_RST           16'h0000

// ==========================================================
// status and mask registers
`define LCEA_STAT_W            32
`define LCEA_STAT_DONE_BIT     5
`define LCEA_STAT_RST          32'h0000_0000
`define LCEA_MASK_RST          32'h0000_0000

// ==========================================================
// energy registers
`define LCEA_NRG_W             32
`define LCEA_NRG_RST           32'h0000_0000
`define LCEA_PHASES            3

`endif
